// ---- rtl/atten_pkg.sv ----
// Constants and types shared by the attenuator control ends
package atten_pkg;
   // ****************************************************************
   // Word layout
   // ****************************************************************
   localparam int                ATTEN_W        = 5;
   localparam int                SHIFT_W        = 6;
   localparam int                START_BIT_POS  = 5;
   localparam int                BIT_8DB_POS    = 4;
   localparam int                BIT_4DB_POS    = 3;
   localparam int                BIT_2DB_POS    = 2;
   localparam int                BIT_1DB_POS    = 1;
   localparam int                BIT_HALF_POS   = 0;
   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [4:0]        ATTEN_REF_LOSS = 5'h00;
   localparam logic [4:0]        ATTEN_8DB      = 5'h10;
   localparam logic [5:0]        SHIFT_RESET    = 6'h00;
   localparam logic [4:0]        ATTEN_RESET    = 5'h00;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int                MCLK_PERIOD_NS = 8;
   localparam int                SER_HALF_NS    = 64;
   localparam int                SER_HALF_CYC   = (SER_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int                LE_PULSE_NS    = 64;
   localparam int                LE_PULSE_CYC   = (LE_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int                SWITCH_RATE_HZ = 25000;
   localparam int                SWITCH_GAP_CYC = (1000000000 / SWITCH_RATE_HZ + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   typedef enum logic [2:0] {
      CT_IDLE  = 3'b000,
      CT_PAR   = 3'b001,
      CT_SLOW  = 3'b010,
      CT_SHIGH = 3'b011,
      CT_LEHI  = 3'b100,
      CT_GAP   = 3'b101
   } ctrl_state_t;
endpackage : atten_pkg

// ---- rtl/atten_if.sv ----
// Pin-level link between controller and attenuator
`timescale 1ns/100ps
`default_nettype none
interface atten_if;
   logic [4:0] atten_bits;
   logic       word_capture_strobe;
   logic       serial_data;
   logic       serial_clock;
   logic       serial_sel;
   logic       powerup_preset_select;

   modport device (
      input atten_bits, word_capture_strobe, serial_data, serial_clock,
            serial_sel, powerup_preset_select
   );
   modport controller (
      output atten_bits, word_capture_strobe, serial_data, serial_clock,
             serial_sel, powerup_preset_select
   );
endinterface : atten_if
`default_nettype wire

// ---- rtl/sync2.sv ----
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         resetn,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sync2
`default_nettype wire

// ---- rtl/atten_device.sv ----
// Attenuator control logic: parallel, direct and serial paths
// Summary of operation
// - Select input low parallel, high serial
// - Five weighted bits 8,4,2,1,0.5 dB
// - Controller pulses strobe after changing bits
// - Strobe high makes parallel bits direct
// - Six-bit shift register behind transparent latch
// - Shifting ignores strobe level
// - Strobe high passes register, low holds
// - Controller loads word with strobe low; controller still holds strobe high while shifting if use_direct is set
// - Controller sends start bit as zero
// - Word sent most significant bit first
// - Data sampled on rising serial clock
// - Serial power-up loads parallel input bits
// - Parallel power-up, strobe low: preset select
// - Parallel power-up, strobe high: follow bits
// - Controller keeps changes under 25 kHz
`timescale 1ns/100ps
`default_nettype none
module atten_device
   import atten_pkg::*;
(
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         resetn,
   // Pins from the controller
   atten_if.device           pins,
   // Attenuator drive
   output logic [ATTEN_W-1:0] atten_state,
   output logic              start_bit_error
);
   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   logic [4:0] bits_s;
   logic       le_s;
   logic       sd_s;
   logic       sck_s;
   logic       ps_s;
   logic       pup_s;

   sync2 #(.W(10)) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .d      ({pins.atten_bits, pins.word_capture_strobe,
                pins.serial_data, pins.serial_clock, pins.serial_sel,
                pins.powerup_preset_select}),
      .q      ({bits_s, le_s, sd_s, sck_s, ps_s, pup_s})
   );

   // ****************************************************************
   // Power-up sampling
   // ****************************************************************
   logic [2:0]          init_cnt_q;
   logic                init_done_q;
   logic [SHIFT_W-1:0]  shift_q;
   logic [SHIFT_W-1:0]  shift_d;
   logic                sck_d1_q;
   logic [ATTEN_W-1:0]  atten_q;
   logic [ATTEN_W-1:0]  atten_d;
   logic [ATTEN_W-1:0]  preset_val;
   wire                 sync_ready = (init_cnt_q == 3'h2);
   wire                 sck_rise   = sck_s & ~sck_d1_q;

   // Preset taken once the synchronisers hold pin levels
   assign preset_val = ps_s ? bits_s :
                       le_s ? bits_s :
                       (pup_s ? ATTEN_8DB : ATTEN_REF_LOSS);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         init_cnt_q  <= 3'h0;
         init_done_q <= 1'b0;
      end else if (!init_done_q) begin
         init_cnt_q  <= init_cnt_q + 3'h1;
         init_done_q <= sync_ready;
      end
   end

   // ****************************************************************
   // Serial shift register
   // ****************************************************************
   assign shift_d = sck_rise ? {shift_q[SHIFT_W-2:0], sd_s}
                             : shift_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shift_q  <= SHIFT_RESET;
         sck_d1_q <= 1'b0;
      end else begin
         shift_q  <= init_done_q ? shift_d : SHIFT_RESET;
         sck_d1_q <= sck_s;
      end
   end

   // ****************************************************************
   // Attenuation latch
   // ****************************************************************
   always_comb begin
      atten_d = atten_q;
      if (!init_done_q) begin
         atten_d = sync_ready ? preset_val : atten_q;
      end else if (le_s) begin
         atten_d = ps_s ? shift_q[ATTEN_W-1:0]
                        : bits_s;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         atten_q         <= ATTEN_RESET;
         start_bit_error <= 1'b0;
      end else begin
         atten_q         <= atten_d;
         start_bit_error <= init_done_q & ps_s & le_s
                            & shift_q[START_BIT_POS];
      end
   end

   assign atten_state = atten_q;
endmodule : atten_device
`default_nettype wire

// ---- rtl/atten_controller.sv ----
// External controller: drives parallel or serial programming
`timescale 1ns/100ps
`default_nettype none
module atten_controller
   import atten_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              resetn,
   // Pins to the device
   atten_if.controller            pins,
   // User side
   input  wire logic              use_serial,
   input  wire logic              use_direct,
   input  wire logic              preset_high,
   input  wire logic              req_valid,
   input  wire logic [ATTEN_W-1:0] req_atten,
   output logic                   req_ready
);
   ctrl_state_t          state_q;
   logic [SHIFT_W-1:0]   word_q;
   logic [2:0]           bit_cnt_q;
   logic [15:0]          tmr_q;
   logic [ATTEN_W-1:0]   bits_q;
   logic                 le_q;
   logic                 sck_q;
   logic                 sd_q;
   wire                  tmr_zero = (tmr_q == 16'h0);

   assign req_ready = (state_q == CT_IDLE);
   assign pins.atten_bits            = bits_q;
   assign pins.word_capture_strobe   = le_q | use_direct;
   assign pins.serial_data           = sd_q;
   assign pins.serial_clock          = sck_q;
   assign pins.serial_sel            = use_serial;
   assign pins.powerup_preset_select = preset_high;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q   <= CT_IDLE;
         word_q    <= SHIFT_RESET;
         bit_cnt_q <= 3'h0;
         tmr_q     <= 16'h0;
         bits_q    <= ATTEN_RESET;
         le_q      <= 1'b0;
         sck_q     <= 1'b0;
         sd_q      <= 1'b0;
      end else begin
         if (!tmr_zero) tmr_q <= tmr_q - 16'h1;
         unique case (state_q)
            CT_IDLE: begin
               if (req_valid) begin
                  if (use_serial) begin
                     word_q    <= {1'b0, req_atten};
                     bit_cnt_q <= 3'h6;
                     state_q   <= CT_SLOW;
                  end else begin
                     bits_q  <= req_atten;
                     tmr_q   <= 16'(LE_PULSE_CYC);
                     state_q <= CT_PAR;
                  end
               end
            end
            CT_PAR: if (tmr_zero) begin
               le_q    <= 1'b1;
               tmr_q   <= 16'(LE_PULSE_CYC);
               state_q <= CT_LEHI;
            end
            CT_SLOW: if (tmr_zero) begin
               if (bit_cnt_q == 3'h0) begin
                  le_q    <= 1'b1;
                  tmr_q   <= 16'(LE_PULSE_CYC);
                  state_q <= CT_LEHI;
               end else begin
                  sd_q    <= word_q[SHIFT_W-1];
                  word_q  <= {word_q[SHIFT_W-2:0], 1'b0};
                  tmr_q   <= 16'(SER_HALF_CYC);
                  state_q <= CT_SHIGH;
               end
            end
            CT_SHIGH: if (tmr_zero) begin
               sck_q <= ~sck_q;
               if (sck_q) begin
                  bit_cnt_q <= bit_cnt_q - 3'h1;
                  state_q   <= CT_SLOW;
               end
               tmr_q <= 16'(SER_HALF_CYC);
            end
            CT_LEHI: if (tmr_zero) begin
               le_q    <= 1'b0;
               tmr_q   <= 16'(SWITCH_GAP_CYC);
               state_q <= CT_GAP;
            end
            CT_GAP: if (tmr_zero) state_q <= CT_IDLE;
            default: state_q <= CT_IDLE;
         endcase
      end
   end
endmodule : atten_controller
`default_nettype wire

// ---- sim/atten_chk.sv ----
// Checker on the controller-to-attenuator link
`timescale 1ns/100ps
`default_nettype none
module atten_chk
   import atten_pkg::*;
(
   // Clock and reset
   input wire logic               mclk,
   input wire logic               resetn,
   // Link signals
   input wire logic [4:0]         atten_bits,
   input wire logic               word_capture_strobe,
   input wire logic               serial_data,
   input wire logic               serial_clock,
   input wire logic               serial_sel,
   input wire logic               powerup_preset_select,
   // Device outputs
   input wire logic [ATTEN_W-1:0] atten_state,
   input wire logic               start_bit_error
);
   logic [3:0] up_q;
   wire        up = (up_q == 4'hF);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) up_q <= 4'h0;
      else if (!up) up_q <= up_q + 4'h1;
   end
   // Cycles since the strobe last fell, saturating
   logic        strobe_q;
   logic [15:0] gap_q;
   wire         gap_full = (gap_q == 16'(SWITCH_GAP_CYC));
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         strobe_q <= 1'b0;
         gap_q    <= 16'(SWITCH_GAP_CYC);
      end else begin
         strobe_q <= word_capture_strobe;
         if (strobe_q && !word_capture_strobe) gap_q <= 16'h0000;
         else if (!gap_full) gap_q <= gap_q + 16'h0001;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   chk_direct_follow: assert property ((up && !serial_sel &&
      word_capture_strobe && $stable(atten_bits))[*5]
      |-> atten_state == atten_bits) else $error("bits not followed");
   chk_latch_hold: assert property ((up && !word_capture_strobe
      && $stable(serial_sel))[*5] |-> $stable(atten_state))
      else $error("state moved while strobe low");
   chk_data_hold: assert property (serial_clock &&
      $past(serial_clock) |-> $stable(serial_data))
      else $error("data moved while clock high");
   chk_data_setup: assert property ($rose(serial_clock) |->
      $stable(serial_data) && serial_data == $past(serial_data, 4))
      else $error("data not set up");
   chk_shift_strobe: assert property (serial_sel &&
      $rose(serial_clock) |-> !word_capture_strobe)
      else $error("shift with strobe high");
   chk_start_clear: assert property ((up && serial_sel &&
      word_capture_strobe)[*5] |-> !start_bit_error)
      else $error("start bit flagged");
   chk_reset_zero: assert property (up_q == 4'h1 |->
      atten_state == ATTEN_RESET) else $error("bad reset state");
   chk_bits_frozen: assert property ($rose(word_capture_strobe)
      && !serial_sel |-> $stable(atten_bits)[*3])
      else $error("bits moved in strobe");
   chk_switch_gap: assert property ($rose(word_capture_strobe) |->
      gap_full) else $error("strobe pulses too close");
   chk_preset_load: assert property (up_q == 4'h4 && !serial_sel &&
      !word_capture_strobe |-> atten_state == (powerup_preset_select
      ? ATTEN_8DB : ATTEN_REF_LOSS)) else $error("bad preset state");
endmodule : atten_chk
`default_nettype wire

// ---- sim/tb_step_attenuator_control_interface.sv ----
// Self-checking bench for the attenuator control link
`timescale 1ns/100ps
`default_nettype none
module tb_step_attenuator_control_interface
   import atten_pkg::*;
;
   logic       mclk = 1'b0;
   logic       resetn = 1'b0;
   logic       rst2_n = 1'b0;
   logic       use_serial = 1'b0;
   logic       use_direct = 1'b0;
   logic       req_valid = 1'b0;
   logic [4:0] req_atten = 5'h00;
   logic       req_ready;
   logic [4:0] state1, state2;
   logic       err1, err2;
   logic [5:0] cap_q = 6'h00;
   int         bits_seen = 0;
   int         error_cnt = 0;
   int         tests_run = 0;
   logic [4:0] vals [6] = '{5'h1F, 5'h01, 5'h10, 5'h15, 5'h0A, 5'h1F};
   atten_if if1 ();
   atten_if if2 ();
   atten_controller u_atten_controller (.mclk(mclk), .resetn(resetn),
      .pins(if1.controller), .use_serial(use_serial),
      .use_direct(use_direct), .preset_high(1'b0), .req_valid(req_valid),
      .req_atten(req_atten), .req_ready(req_ready));
   atten_device u_atten_device (.mclk(mclk), .resetn(resetn),
      .pins(if1.device), .atten_state(state1), .start_bit_error(err1));
   atten_device u_atten_device_2 (.mclk(mclk), .resetn(rst2_n),
      .pins(if2.device), .atten_state(state2), .start_bit_error(err2));
   atten_chk u_atten_chk (.mclk(mclk), .resetn(resetn),
      .atten_bits(if1.atten_bits), .serial_data(if1.serial_data),
      .word_capture_strobe(if1.word_capture_strobe),
      .serial_clock(if1.serial_clock), .serial_sel(if1.serial_sel),
      .powerup_preset_select(if1.powerup_preset_select),
      .atten_state(state1), .start_bit_error(err1));
   always #4 mclk = ~mclk;
   always @(posedge if1.serial_clock) begin
      cap_q <= {cap_q[4:0], if1.serial_data};
      bits_seen++;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic check(input logic [5:0] got, input logic [5:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic send(input logic [4:0] v);
      bits_seen = 0;
      req_valid = 1'b1;
      req_atten = v;
      tick(1);
      req_valid = 1'b0;
      tick(1);
      for (int n = 0; n < 9000 && req_ready !== 1'b1; n++) tick(1);
      check({5'h00, req_ready}, 6'h01);
      check({1'b0, state1}, {1'b0, v});
   endtask : send
   task automatic pup(input logic s, le, p, input logic [4:0] b, e);
      rst2_n = 1'b0;
      if2.serial_sel = s;
      if2.word_capture_strobe = le;
      if2.powerup_preset_select = p;
      if2.atten_bits = b;
      tick(12);
      rst2_n = 1'b1;
      tick(6);
      check({1'b0, state2}, {1'b0, e});
   endtask : pup
   task automatic shift2(input logic [5:0] w);
      for (int i = 5; i >= 0; i--) begin
         if2.serial_data = w[i];
         tick(4);
         if2.serial_clock = 1'b1;
         tick(4);
         if2.serial_clock = 1'b0;
      end
      if2.serial_data = ~w[0];
      tick(4);
   endtask : shift2
   task automatic report_and_stop;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   initial begin
      #600000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      if2.serial_data = 1'b0;
      if2.serial_clock = 1'b0;
      pup(1'b0, 1'b0, 1'b0, 5'h1F, ATTEN_REF_LOSS);
      pup(1'b0, 1'b0, 1'b1, 5'h03, ATTEN_8DB);
      if2.atten_bits = 5'h07;
      tick(6);
      check({1'b0, state2}, {1'b0, ATTEN_8DB});
      if2.word_capture_strobe = 1'b1;
      tick(2);
      if2.word_capture_strobe = 1'b0;
      tick(6);
      check({1'b0, state2}, 6'h07);
      pup(1'b0, 1'b1, 1'b1, 5'h06, 5'h06);
      pup(1'b1, 1'b0, 1'b0, 5'h0B, 5'h0B);
      shift2(6'h2A);
      check({1'b0, state2}, 6'h0B);
      if2.word_capture_strobe = 1'b1;
      tick(6);
      check({1'b0, state2}, 6'h0A);
      check({5'h00, err2}, 6'h01);
      shift2(6'h15);
      check({1'b0, state2}, 6'h15);
      check({5'h00, err2}, 6'h00);
      tick(12);
      resetn = 1'b1;
      tick(2);
      for (int i = 0; i < 6; i++) begin
         use_serial = (i > 2);
         tick(2);
         send(vals[i]);
         if (use_serial) begin
            check(cap_q, {1'b0, vals[i]});
            check(6'(bits_seen), 6'h06);
         end
      end
      use_serial = 1'b0;
      use_direct = 1'b1;
      tick(2);
      send(5'h06);
      report_and_stop;
   end
endmodule : tb_step_attenuator_control_interface
`default_nettype wire
